// ### hw/cac_regs.svh
// Register offsets, field positions and reset values of the alarm comparator.
// Assumes inclusion by bare name from the design file and testbench.
`ifndef CAC_REGS_SVH
`define CAC_REGS_SVH
`define CAC_OFF_HIGH_TRIP 12'h000
`define CAC_OFF_HIGH_REL 12'h004
`define CAC_OFF_LOW_TRIP 12'h008
`define CAC_OFF_LOW_REL 12'h00c
`define CAC_OFF_CFG 12'h010
`define CAC_OFF_STATUS 12'h014
`define CAC_OFF_IRQ_STAT 12'h018
`define CAC_OFF_IRQ_MASK 12'h01c
`define CAC_CFG_HIGH_OD 0
`define CAC_CFG_HIGH_POL 1
`define CAC_CFG_LOW_OD 2
`define CAC_CFG_LOW_POL 3
`define CAC_CFG_SEL_LSB 4
`define CAC_CFG_SLEEP 6
`define CAC_IRQ_HIGH 0
`define CAC_IRQ_LOW 1
`define CAC_IRQ_DONE 2
`define CAC_RST_LEVEL 14'h0000
`define CAC_RST_CFG 7'h00
`define CAC_RST_IRQ 3'h0
`endif

// ### hw/cac_pkg.sv
// Types of the alarm comparator.
// Assumes the register header sits on the include path.
package cac_pkg;
    typedef enum logic [1:0] {
        CAC_SEL_DIGITAL = 2'b00,
        CAC_SEL_CAP_DENSITY = 2'b01,
        CAC_SEL_TEMP_DENSITY = 2'b10,
        CAC_SEL_BOTH_DENSITY = 2'b11
    } cac_out_sel_e;
    typedef logic [13:0] cac_level_t;
endpackage

// ### hw/cac_alarm_comparator.sv
// Two hysteresis alarm comparators on the corrected capacitance, APB slave.
// Assumes conversion strobe, result and density streams come from pclk logic.
// Function
// - Alarms change only at conversion completion.
// - Four 14-bit unsigned threshold levels.
// - High alarm trips above on, releases below off.
// - Low alarm trips below on, releases above off.
// - Hysteresis lies between trip and release levels.
// - Both alarms run alongside any output mode.
// - Both density streams leave only high alarm.
// - Alarms update in continuous and sleep operation.
// - Each pin configured by its own field.
// - Per pin push-pull or open-drain driver.
// - Polarity zero drives pin high when active.
// - Polarity one drives pin low when active.
// - Inverted low pin becomes second high alarm.
// - Inverted high pin becomes second low alarm.
// - Temperature stream takes the low alarm pin.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "cac_regs.svh"
module cac_alarm_comparator
    import cac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done,
    input wire logic [13:0] corrected_cap,
    input wire logic temperature_density_stream,
    output logic measure_wake_request,
    output logic alarm_high_out,
    output logic alarm_high_oe,
    output logic alarm_low_out,
    output logic alarm_low_oe,
    output logic irq
);
    cac_level_t high_trip_level_reg;
    cac_level_t high_release_level_reg;
    cac_level_t low_trip_level_reg;
    cac_level_t low_release_level_reg;
    logic [6:0] cfg_reg;
    logic high_active_reg;
    logic low_active_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [13:0] last_cap_reg;
    logic high_next;
    logic low_next;
    logic high_pin_next;
    logic low_pin_next;
    logic high_oe_next;
    logic low_oe_next;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rdata_next;
    logic [2:0] irq_set;
    cac_out_sel_e out_sel;

    // Trip when at or above the upper level, release when at or below the lower.
    function automatic logic hyst_rise(input logic act,
            input logic [13:0] v, input logic [13:0] up,
            input logic [13:0] dn);
        if (!act) begin
            hyst_rise = (v >= up);
        end else begin
            hyst_rise = !(v <= dn);
        end
    endfunction

    // Trip when at or below the lower level, release at or above the upper.
    function automatic logic hyst_fall(input logic act,
            input logic [13:0] v, input logic [13:0] dn,
            input logic [13:0] up);
        if (!act) begin
            hyst_fall = (v <= dn);
        end else begin
            hyst_fall = !(v >= up);
        end
    endfunction

    // Pin level: active follows polarity, open-drain only pulls low.
    function automatic logic [1:0] pin_drive(input logic act,
            input logic pol, input logic od);
        logic lvl;
        lvl = act ^ pol;
        if (od) begin
            pin_drive = {1'b0, !lvl};
        end else begin
            pin_drive = {lvl, 1'b1};
        end
    endfunction

    assign out_sel = cac_out_sel_e'(cfg_reg[`CAC_CFG_SEL_LSB +: 2]);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `CAC_OFF_IRQ_MASK);

    always_comb begin
        // Inverting polarity swaps trip and release roles.
        if (cfg_reg[`CAC_CFG_HIGH_POL]) begin
            high_next = hyst_fall(high_active_reg, corrected_cap,
                high_release_level_reg, high_trip_level_reg);
        end else begin
            high_next = hyst_rise(high_active_reg, corrected_cap,
                high_trip_level_reg, high_release_level_reg);
        end
        if (cfg_reg[`CAC_CFG_LOW_POL]) begin
            low_next = hyst_rise(low_active_reg, corrected_cap,
                low_release_level_reg, low_trip_level_reg);
        end else begin
            low_next = hyst_fall(low_active_reg, corrected_cap,
                low_trip_level_reg, low_release_level_reg);
        end
    end

    always_comb begin
        // Each pin reads only its own field of the configuration.
        {high_pin_next, high_oe_next} = pin_drive(high_active_reg,
            cfg_reg[`CAC_CFG_HIGH_POL], cfg_reg[`CAC_CFG_HIGH_OD]);
        {low_pin_next, low_oe_next} = pin_drive(low_active_reg,
            cfg_reg[`CAC_CFG_LOW_POL], cfg_reg[`CAC_CFG_LOW_OD]);
        // Temperature stream claims the low pin as push-pull.
        if (out_sel == CAC_SEL_TEMP_DENSITY ||
                out_sel == CAC_SEL_BOTH_DENSITY) begin
            low_pin_next = temperature_density_stream;
            low_oe_next = 1'b1;
        end
    end

    // Alarm state moves only on the completion strobe, in any mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_active_reg <= 1'b0;
            low_active_reg <= 1'b0;
            last_cap_reg <= `CAC_RST_LEVEL;
        end else if (conv_done) begin
            high_active_reg <= high_next;
            low_active_reg <= low_next;
            last_cap_reg <= corrected_cap;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_high_out <= 1'b0;
            alarm_high_oe <= 1'b1;
            alarm_low_out <= 1'b0;
            alarm_low_oe <= 1'b1;
        end else begin
            alarm_high_out <= high_pin_next;
            alarm_high_oe <= high_oe_next;
            alarm_low_out <= low_pin_next;
            alarm_low_oe <= low_oe_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_trip_level_reg <= `CAC_RST_LEVEL;
            high_release_level_reg <= `CAC_RST_LEVEL;
            low_trip_level_reg <= `CAC_RST_LEVEL;
            low_release_level_reg <= `CAC_RST_LEVEL;
            cfg_reg <= `CAC_RST_CFG;
            irq_mask_reg <= `CAC_RST_IRQ;
        end else if (wr_en && pstrb[0] && pstrb[1]) begin
            unique case (paddr)
                `CAC_OFF_HIGH_TRIP: high_trip_level_reg <= pwdata[13:0];
                `CAC_OFF_HIGH_REL: high_release_level_reg <= pwdata[13:0];
                `CAC_OFF_LOW_TRIP: low_trip_level_reg <= pwdata[13:0];
                `CAC_OFF_LOW_REL: low_release_level_reg <= pwdata[13:0];
                `CAC_OFF_CFG: cfg_reg <= pwdata[6:0];
                `CAC_OFF_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // Wake request pulses once per write of status bit 0 while the sleep bit is set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            measure_wake_request <= 1'b0;
        end else begin
            measure_wake_request <= wr_en && pstrb[0] &&
                (paddr == `CAC_OFF_STATUS) && pwdata[0] &&
                cfg_reg[`CAC_CFG_SLEEP];
        end
    end

    assign irq_set = {conv_done,
        conv_done && (low_next != low_active_reg),
        conv_done && (high_next != high_active_reg)};

    // A new event in the clearing cycle wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= `CAC_RST_IRQ;
        end else if (wr_en && pstrb[0] && paddr == `CAC_OFF_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (paddr)
            `CAC_OFF_HIGH_TRIP: rdata_next[13:0] = high_trip_level_reg;
            `CAC_OFF_HIGH_REL: rdata_next[13:0] = high_release_level_reg;
            `CAC_OFF_LOW_TRIP: rdata_next[13:0] = low_trip_level_reg;
            `CAC_OFF_LOW_REL: rdata_next[13:0] = low_release_level_reg;
            `CAC_OFF_CFG: rdata_next[6:0] = cfg_reg;
            `CAC_OFF_STATUS: rdata_next[29:0] = {last_cap_reg, 14'h0000,
                low_active_reg, high_active_reg};
            `CAC_OFF_IRQ_STAT: rdata_next[2:0] = irq_stat_reg;
            `CAC_OFF_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Registered read data adds no wait state but keeps outputs clean.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en) begin
                prdata <= rdata_next;
            end
        end
    end

    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !conv_done |=> $stable(high_active_reg) && $stable(low_active_reg))
        else $error("alarm changed without conversion");
    AST_HIGH_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !cfg_reg[`CAC_CFG_HIGH_POL] && !high_active_reg &&
        corrected_cap >= high_trip_level_reg |=> high_active_reg)
        else $error("high alarm failed to trip");
    AST_HIGH_REL: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !cfg_reg[`CAC_CFG_HIGH_POL] && high_active_reg &&
        corrected_cap <= high_release_level_reg |=> !high_active_reg)
        else $error("high alarm failed to release");
    AST_LOW_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !cfg_reg[`CAC_CFG_LOW_POL] && !low_active_reg &&
        corrected_cap <= low_trip_level_reg |=> low_active_reg)
        else $error("low alarm failed to trip");
    AST_LOW_INV: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && cfg_reg[`CAC_CFG_LOW_POL] && !low_active_reg &&
        corrected_cap >= low_release_level_reg |=> low_active_reg)
        else $error("inverted low alarm failed to trip");
    AST_HIGH_INV: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && cfg_reg[`CAC_CFG_HIGH_POL] && !high_active_reg &&
        corrected_cap <= high_release_level_reg |=> high_active_reg)
        else $error("inverted high alarm failed to trip");
    AST_PUSH_PULL: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_reg[`CAC_CFG_HIGH_OD] && $stable(cfg_reg) |=>
        alarm_high_oe && alarm_high_out ==
        ($past(high_active_reg) ^ $past(cfg_reg[`CAC_CFG_HIGH_POL])))
        else $error("push-pull high pin level wrong");
    AST_OPEN_DRAIN: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cfg_reg[`CAC_CFG_HIGH_OD]) |-> !alarm_high_out)
        else $error("open-drain pin drove high");
    AST_TEMP_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cfg_reg[`CAC_CFG_SEL_LSB + 1]) |-> alarm_low_out ==
        $past(temperature_density_stream))
        else $error("temperature stream not on low pin");
    // Release and hold checks pin the hysteresis band from both sides at polarity zero, so
    // a comparator there that ignores its release level cannot slip through.
    AST_LOW_REL: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !cfg_reg[`CAC_CFG_LOW_POL] && low_active_reg &&
        corrected_cap >= low_release_level_reg |=> !low_active_reg)
        else $error("low alarm failed to release");
    AST_HIGH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !cfg_reg[`CAC_CFG_HIGH_POL] && high_active_reg &&
        corrected_cap > high_release_level_reg |=> high_active_reg)
        else $error("high alarm left its band early");
    AST_LOW_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !cfg_reg[`CAC_CFG_LOW_POL] && low_active_reg &&
        corrected_cap < low_release_level_reg |=> low_active_reg)
        else $error("low alarm left its band early");
    AST_LOW_INV_REL: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && cfg_reg[`CAC_CFG_LOW_POL] && low_active_reg &&
        corrected_cap <= low_trip_level_reg |=> !low_active_reg)
        else $error("inverted low alarm failed to release");
    AST_HIGH_INV_REL: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && cfg_reg[`CAC_CFG_HIGH_POL] && high_active_reg &&
        corrected_cap >= high_trip_level_reg |=> !high_active_reg)
        else $error("inverted high alarm failed to release");
    AST_LOW_PUSH_PULL: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_reg[`CAC_CFG_LOW_OD] && !cfg_reg[`CAC_CFG_SEL_LSB + 1] &&
        $stable(cfg_reg) |=> alarm_low_oe && alarm_low_out ==
        ($past(low_active_reg) ^ $past(cfg_reg[`CAC_CFG_LOW_POL])))
        else $error("push-pull low pin level wrong");
    AST_LOW_OPEN_DRAIN: assert property (@(posedge pclk)
        disable iff (!presetn)
        $past(cfg_reg[`CAC_CFG_LOW_OD]) &&
        !$past(cfg_reg[`CAC_CFG_SEL_LSB + 1]) |-> !alarm_low_out)
        else $error("open-drain low pin drove high");
    AST_HIGH_OD_OE: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cfg_reg[`CAC_CFG_HIGH_OD]) |-> alarm_high_oe ==
        !($past(high_active_reg) ^ $past(cfg_reg[`CAC_CFG_HIGH_POL])))
        else $error("open-drain high enable wrong");
    AST_TEMP_OE: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cfg_reg[`CAC_CFG_SEL_LSB + 1]) |-> alarm_low_oe)
        else $error("temperature stream not driven");
    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        irq == $past(|(irq_stat_reg & irq_mask_reg)))
        else $error("interrupt level wrong");
    AST_STAT_SET: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done |=> irq_stat_reg[`CAC_IRQ_DONE])
        else $error("completion event lost against clear");
    AST_LAST_CAP: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done |=> last_cap_reg == $past(corrected_cap))
        else $error("last result not captured");
    AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
        measure_wake_request |-> $past(cfg_reg[`CAC_CFG_SLEEP]))
        else $error("wake request outside sleep operation");
    AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("bus answer missing after setup");
    AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("bus answer held too long");
    AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag without bus answer");
    COV_INV: cover property (@(posedge pclk) disable iff (!presetn)
        cfg_reg[`CAC_CFG_HIGH_POL] && cfg_reg[`CAC_CFG_LOW_POL] &&
        high_active_reg && low_active_reg);
    COV_HIGH: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(high_active_reg));
    COV_LOW: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(low_active_reg));
    COV_BOTH: cover property (@(posedge pclk) disable iff (!presetn)
        high_active_reg && low_active_reg);
    COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(irq));
endmodule

// ### dv/cac_load_model.sv
// Load model on the two alarm pins, a pull-up resistor on each wire.
// Assumes out/oe pairs from the comparator, oe high while it drives.
`timescale 1ns/1ps
module cac_load_model (
    input wire logic high_out,
    input wire logic high_oe,
    input wire logic low_out,
    input wire logic low_oe,
    output logic high_level,
    output logic low_level
);
    // A released wire goes to the pull-up level, not to the last value.
    assign high_level = high_oe ? high_out : 1'b1;
    assign low_level = low_oe ? low_out : 1'b1;
endmodule

// ### dv/testbench.sv
// Self-checking bench for the alarm comparator over APB.
// Assumes the load model resolves the pin levels that the bench checks.
`timescale 1ns/1ps
`include "cac_regs.svh"
module testbench;
    import cac_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, conv_done = 1'b0, temp = 1'b0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    logic [13:0] corrected_cap = 14'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, wake, hi_out, hi_oe, lo_out, lo_oe, irq;
    wire logic hi_lvl, lo_lvl;
    int n_errors = 0, compares = 0, n_wake = 0;
    logic [13:0] caps [13] = '{14'd99, 14'd100, 14'd81, 14'd80, 14'd21,
        14'd20, 14'd39, 14'd40, 14'd50, 14'd90, 14'd100, 14'd30, 14'd20};
    logic [1:0] lv [13] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b00, 2'b01,
        2'b01, 2'b00, 2'b00, 2'b00, 2'b10, 2'b00, 2'b01};
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (wake === 1'b1) n_wake <= n_wake + 1;
    cac_alarm_comparator i_cac_alarm_comparator (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
        .corrected_cap(corrected_cap), .temperature_density_stream(temp),
        .measure_wake_request(wake), .alarm_high_out(hi_out),
        .alarm_high_oe(hi_oe), .alarm_low_out(lo_out),
        .alarm_low_oe(lo_oe), .irq(irq));
    cac_load_model i_cac_load_model (.high_out(hi_out), .high_oe(hi_oe),
        .low_out(lo_out), .low_oe(lo_oe), .high_level(hi_lvl),
        .low_level(lo_lvl));
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // The answer is taken at the rising edge that shows pready high, and
    // the request is released at that same edge by non-blocking update.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t no bus answer", $time);
            complete_run();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x, "register read");
    endtask
    task automatic conv(input logic [13:0] v);
        @(posedge pclk);
        conv_done <= 1'b1;
        corrected_cap <= v;
        @(posedge pclk);
        conv_done <= 1'b0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({hi_lvl, lo_lvl}, 2'b00, "reset pins");
        rd(`CAC_OFF_LOW_REL, 32'h0);
        wr(`CAC_OFF_HIGH_REL, 32'hffff_ffff);
        rd(`CAC_OFF_HIGH_REL, 32'h0000_3fff);
        wr(`CAC_OFF_HIGH_TRIP, 32'd100);
        wr(`CAC_OFF_HIGH_REL, 32'd80);
        wr(`CAC_OFF_LOW_TRIP, 32'd20);
        wr(`CAC_OFF_LOW_REL, 32'd40);
        for (int i = 0; i < 13; i++) begin
            if (i == 8) wr(`CAC_OFF_CFG, 32'h0000_000b);
            conv(caps[i]);
            chk({hi_lvl, lo_lvl}, lv[i], "pins");
            if (i == 10) chk(hi_oe, 1'b0, "open drain");
        end
        $display("test hysteresis and polarity done");
        @(posedge pclk);
        corrected_cap <= 14'd0;
        repeat (4) @(negedge pclk);
        chk(lo_lvl, 1'b1, "no strobe");
        rd(`CAC_OFF_STATUS, 32'h0014_0001);
        rd(`CAC_OFF_IRQ_STAT, 32'h0000_0007);
        wr(`CAC_OFF_IRQ_MASK, 32'h4);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b1, "irq raised");
        wr(`CAC_OFF_IRQ_STAT, 32'h7);
        rd(`CAC_OFF_IRQ_STAT, 32'h0);
        chk(irq, 1'b0, "irq cleared");
        apb(1'b0, 12'h020, 32'h0);
        chk(q, 32'h0, "unmapped data");
        chk(e, 1'b1, "unmapped error");
        $display("test interrupts done");
        for (int s = 2; s < 4; s++) begin
            wr(`CAC_OFF_CFG, 32'(s) << 4);
            temp <= 1'b1;
            conv(14'd100);
            chk({hi_lvl, lo_lvl}, 2'b11, "density");
            @(posedge pclk);
            temp <= 1'b0;
            repeat (3) @(negedge pclk);
            chk(lo_lvl, 1'b0, "density low");
        end
        $display("test density done");
        wr(`CAC_OFF_CFG, 32'h0);
        wr(`CAC_OFF_STATUS, 32'h1);
        chk(n_wake, 32'd0, "wake ignored");
        wr(`CAC_OFF_CFG, 32'h40);
        wr(`CAC_OFF_STATUS, 32'h1);
        repeat (3) @(negedge pclk);
        chk(n_wake, 32'd1, "wake pulse");
        $display("test sleep done");
        complete_run();
    end
endmodule
